//--- core/cpc_pkg.sv
// Purpose: shared constants and types for the configuration port pin control block
// Assumes: 10 MHz system clock, AHB-Lite register access, 32-bit data
// Notes: all offsets, reset values and cycle counts live here
package cpc_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00; // restart and after-load pin control
	localparam logic [7:0] ADDR_LEN = 8'h04; // configuration length in bytes
	localparam logic [7:0] ADDR_STAT = 8'h08; // state, mode, flags
	localparam logic [7:0] ADDR_DATA = 8'h0c; // last byte and byte count

	// control register fields
	localparam int CTRL_RESTART = 0; // write 1: restart configuration
	localparam int CTRL_LOW_VAL = 1; // busy-low pin level after load
	localparam int CTRL_LOW_OE = 2; // busy-low pin driven after load
	localparam int CTRL_HIGH_VAL = 3; // busy-high pin level after load
	localparam int CTRL_HIGH_OE = 4; // busy-high pin driven after load
	// busy-low driven high after load so an enabled memory stays off
	localparam logic [4:0] CTRL_RST = 5'h06;
	localparam logic [15:0] LEN_RST = 16'h0010;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int POR_SHORT_CYC = 16384; // mode bit 0 high
	localparam int POR_LONG_CYC = 65536; // mode bit 0 low
	localparam logic [16:0] POR_SETTLE = 17'h00003; // synchroniser settle before sampling
	localparam logic [7:0] CLEAR_CYC = 8'h40; // memory clearing time
	localparam logic [2:0] STEP_DIV = 3'h4; // master step rate divider
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// ----------------------------------------------------------------
	// mode pin codes, bit 2 first
	// ----------------------------------------------------------------
	localparam logic [2:0] MODE_SLAVE = 3'h7;
	localparam logic [2:0] MODE_MSER = 3'h0;
	localparam logic [2:0] MODE_PERIPH = 3'h5;
	localparam logic [2:0] MODE_MPAR_HI = 3'h6;
	localparam logic [2:0] MODE_MPAR_LO = 3'h4;
	localparam logic [15:0] ADDR_HI_START = 16'hffff; // counts down
	localparam logic [15:0] ADDR_LO_START = 16'h0000; // counts up

	typedef enum logic [2:0] {ST_POWER, ST_CLEAR, ST_HOLD, ST_LOAD, ST_DONE} cpc_state_type;
	typedef enum logic [2:0] {MD_SLAVE, MD_MSER, MD_PERIPH, MD_MPAR_HI, MD_MPAR_LO} cpc_mode_type;

endpackage

//--- core/cpc_sync.sv
// Purpose: two-flop synchroniser for a group of pin inputs
// Assumes: each bit is an independent level
// Notes: first stage feeds only the second stage
`timescale 1ns/100ps
module cpc_sync #(
	parameter int W = 1
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r; // first stage, read by q only

	// ----------------------------------------------------------------
	// two stages
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule

//--- core/cpc_top.sv
// Purpose: pin-level control of the configuration port while loading runs
// Assumes: pins synchronised into sys_clk; link clock sampled as a level
// Notes: loaded bytes leave on cfg_byte with a one-cycle valid pulse
//
// Local design decisions: the register offsets and the AHB-Lite register port.
`timescale 1ns/100ps

// How it works
// - busy-high pin high while loading, then set by the control register (released at reset value)
// - busy-low pin low while loading, then set by the control register
// - busy-low pin driven high after load (at reset value)
// - init pin low during power-up and clearing
// - hold off while any init line low
// - write only when all four strobes asserted
// - capture byte when any strobe deasserts
// - strobe and third select output address bits
// - ready shows when another byte fits
// - address step strobe rises before address changes
// - sixteen-bit address out in master parallel
// - parallel modes move whole bytes
// - serial input one bit per clock
// - forward serial data on serial output
// - decode the three mode pins
// - strobe pins become user I/O after load
// - weak pull-ups on until load ends
// - sample mode pins just before loading
// - mode bit 0 picks power-on delay
module cpc_top #(
	parameter int POR_SHORT_P = cpc_pkg::POR_SHORT_CYC,
	parameter int POR_LONG_P = cpc_pkg::POR_LONG_CYC
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic mode_select_bit0,
	input wire logic mode_select_bit1,
	input wire logic mode_select_bit2,
	input wire logic cclk_in,
	input wire logic init_n_i,
	output logic init_n_o,
	output logic init_n_oe,
	output logic config_busy_high_flag,
	output logic config_busy_high_flag_oe,
	output logic config_busy_low_flag,
	output logic config_busy_low_flag_oe,
	input wire logic peripheral_select_a_n,
	input wire logic peripheral_select_b_n,
	input wire logic peripheral_select_c_n_i,
	output logic peripheral_select_c_n_o,
	output logic peripheral_select_c_n_oe,
	input wire logic peripheral_write_strobe_i,
	output logic peripheral_write_strobe_o,
	output logic peripheral_write_strobe_oe,
	input wire logic [7:0] config_byte_bus,
	output logic [15:0] memory_address_out,
	output logic memory_address_oe,
	output logic addr_step_strobe,
	output logic addr_step_strobe_oe,
	output logic byte_ready,
	output logic byte_ready_oe,
	output logic serial_data_out,
	output logic serial_data_out_oe,
	output logic weak_pullup_en,
	output logic config_done,
	output logic [7:0] cfg_byte,
	output logic cfg_byte_valid
);
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [16:0] pins_s; // synchronised pin group
	cpc_sync #(.W(17)) u_sync (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.d({mode_select_bit2, mode_select_bit1, mode_select_bit0, init_n_i,
			peripheral_select_a_n, peripheral_select_b_n, peripheral_select_c_n_i,
			peripheral_write_strobe_i, cclk_in, config_byte_bus}),
		.q(pins_s)
	);
	logic [2:0] mode_s; // mode pins, bit 2 first
	logic init_s; // wired-and init line
	logic all_on; // all four write strobes asserted
	logic cclk_s; // link clock level
	logic [7:0] byte_s; // data byte, bit 0 doubles as serial input
	assign mode_s = pins_s[16:14];
	assign init_s = pins_s[13];
	assign all_on = !pins_s[12] && !pins_s[11] && !pins_s[10] && pins_s[9];
	assign cclk_s = pins_s[8];
	assign byte_s = pins_s[7:0];

	// ----------------------------------------------------------------
	// state and registers
	// ----------------------------------------------------------------
	cpc_pkg::cpc_state_type st_r; // sequencer state
	cpc_pkg::cpc_mode_type mode_r; // decoded mode
	logic [2:0] mode_raw_r; // sampled pin levels
	logic [16:0] por_cnt_r; // power-on counter
	logic por_arm_r; // delay choice taken
	logic por_long_r; // long delay chosen
	logic [7:0] clr_cnt_r; // clearing counter
	logic [2:0] div_r; // step divider
	logic step_en; // one-cycle step pulse
	logic cclk_d_r; // link clock, previous sample
	logic all_on_d_r; // strobes, previous sample
	logic [7:0] sh_in_r; // serial assembly
	logic [3:0] bit_cnt_r; // bits assembled
	logic [7:0] sh_out_r; // parallel byte going out serially
	logic [3:0] out_cnt_r; // bits left to send
	logic mp_phase_r; // master parallel: 0 raise strobe, 1 fetch
	logic [15:0] byte_cnt_r; // bytes loaded
	logic [15:0] len_r; // bytes to load
	logic [4:0] ctrl_r; // after-load pin control
	logic restart_r; // restart pulse from software
	logic loading; // loading bytes
	logic cfg_active; // anything before done
	logic more; // bytes still wanted
	logic mpar; // either master parallel mode
	logic bit_evt; // serial bit arrives
	logic cap_evt; // peripheral byte captured
	logic mp_evt; // master parallel byte fetched
	logic byte_evt; // a whole byte is complete
	logic [7:0] byte_val; // that byte
	logic [15:0] addr_nxt; // next memory address
	logic [16:0] por_limit; // chosen power-on delay

	assign loading = st_r == cpc_pkg::ST_LOAD;
	assign cfg_active = st_r != cpc_pkg::ST_DONE;
	assign more = byte_cnt_r != len_r;
	assign mpar = mode_r == cpc_pkg::MD_MPAR_HI || mode_r == cpc_pkg::MD_MPAR_LO;
	assign step_en = loading && div_r == cpc_pkg::STEP_DIV - 3'h1;
	assign por_limit = por_long_r ? 17'(POR_LONG_P - 1) : 17'(POR_SHORT_P - 1);
	// slave takes bits on link clock rises, master serial on its own steps
	assign bit_evt = loading && more && ((mode_r == cpc_pkg::MD_SLAVE && cclk_s && !cclk_d_r)
		|| (mode_r == cpc_pkg::MD_MSER && step_en));
	// the byte lands as the write ends; refused while still sending the last one
	assign cap_evt = loading && more && mode_r == cpc_pkg::MD_PERIPH && all_on_d_r && !all_on
		&& out_cnt_r == 4'h0;
	assign mp_evt = loading && more && mpar && step_en && mp_phase_r && out_cnt_r == 4'h0;
	assign byte_evt = (bit_evt && bit_cnt_r == cpc_pkg::BITS_PER_BYTE - 4'h1) || cap_evt
		|| mp_evt;
	assign byte_val = (cap_evt || mp_evt) ? byte_s : {sh_in_r[6:0], byte_s[0]};
	assign addr_nxt = mode_r == cpc_pkg::MD_MPAR_HI ? memory_address_out - 16'h0001
		: memory_address_out + 16'h0001;

	// ----------------------------------------------------------------
	// power-on delay; mode bit 0 is caught once its synchroniser settles
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			por_cnt_r <= 17'h00000;
			por_arm_r <= 1'b0;
			por_long_r <= 1'b0;
		end else if (st_r == cpc_pkg::ST_POWER) begin
			if (!por_arm_r && por_cnt_r == cpc_pkg::POR_SETTLE) begin
				por_arm_r <= 1'b1;
				por_long_r <= !mode_s[0];
				por_cnt_r <= 17'h00000;
			end else begin
				por_cnt_r <= por_cnt_r + 17'h00001;
			end
		end
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			st_r <= cpc_pkg::ST_POWER;
			mode_r <= cpc_pkg::MD_SLAVE;
			mode_raw_r <= 3'h0;
		end else if (restart_r && st_r != cpc_pkg::ST_POWER) begin
			st_r <= cpc_pkg::ST_CLEAR; // software restart clears again
		end else begin
			unique case (st_r)
				cpc_pkg::ST_POWER: if (por_arm_r && por_cnt_r == por_limit) begin
					st_r <= cpc_pkg::ST_CLEAR;
				end
				cpc_pkg::ST_CLEAR: if (clr_cnt_r == cpc_pkg::CLEAR_CYC) begin
					st_r <= cpc_pkg::ST_HOLD;
				end
				// wait while any device on the wired line still holds it low
				cpc_pkg::ST_HOLD: if (init_s) begin
					st_r <= cpc_pkg::ST_LOAD;
					mode_raw_r <= mode_s;
					unique case (mode_s)
						cpc_pkg::MODE_MSER: mode_r <= cpc_pkg::MD_MSER;
						cpc_pkg::MODE_PERIPH: mode_r <= cpc_pkg::MD_PERIPH;
						cpc_pkg::MODE_MPAR_HI: mode_r <= cpc_pkg::MD_MPAR_HI;
						cpc_pkg::MODE_MPAR_LO: mode_r <= cpc_pkg::MD_MPAR_LO;
						// reserved codes fall back to slave serial
						default: mode_r <= cpc_pkg::MD_SLAVE;
					endcase
				end
				cpc_pkg::ST_LOAD: if (!more && out_cnt_r == 4'h0) begin
					st_r <= cpc_pkg::ST_DONE;
				end
				cpc_pkg::ST_DONE: st_r <= cpc_pkg::ST_DONE;
			endcase
		end
	end

	// clearing time and step divider
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			clr_cnt_r <= 8'h00;
			div_r <= 3'h0;
		end else begin
			clr_cnt_r <= st_r == cpc_pkg::ST_CLEAR ? clr_cnt_r + 8'h01 : 8'h00;
			div_r <= (!loading || step_en) ? 3'h0 : div_r + 3'h1;
		end
	end

	// ----------------------------------------------------------------
	// data path: serial assembly, parallel capture, serial forwarding
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cclk_d_r <= 1'b0;
			all_on_d_r <= 1'b0;
			sh_in_r <= 8'h00;
			bit_cnt_r <= 4'h0;
			sh_out_r <= 8'h00;
			out_cnt_r <= 4'h0;
			serial_data_out <= 1'b0;
			byte_cnt_r <= 16'h0000;
			cfg_byte <= 8'h00;
			cfg_byte_valid <= 1'b0;
		end else begin
			cclk_d_r <= cclk_s;
			all_on_d_r <= all_on;
			cfg_byte_valid <= byte_evt;
			if (!loading) begin
				bit_cnt_r <= 4'h0;
				out_cnt_r <= 4'h0;
				byte_cnt_r <= 16'h0000;
			end else begin
				if (bit_evt) begin
					sh_in_r <= {sh_in_r[6:0], byte_s[0]};
					serial_data_out <= byte_s[0];
					bit_cnt_r <= byte_evt ? 4'h0 : bit_cnt_r + 4'h1;
				end
				// parallel bytes go down the chain msb first, one per step
				if (cap_evt || mp_evt) begin
					sh_out_r <= byte_s;
					out_cnt_r <= cpc_pkg::BITS_PER_BYTE;
				end else if (step_en && out_cnt_r != 4'h0) begin
					serial_data_out <= sh_out_r[7];
					sh_out_r <= {sh_out_r[6:0], 1'b0};
					out_cnt_r <= out_cnt_r - 4'h1;
				end
				if (byte_evt) begin
					cfg_byte <= byte_val;
					byte_cnt_r <= byte_cnt_r + 16'h0001;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// master parallel address walk
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			mp_phase_r <= 1'b0;
			addr_step_strobe <= 1'b0;
			memory_address_out <= cpc_pkg::ADDR_LO_START;
			peripheral_write_strobe_o <= 1'b0;
			peripheral_select_c_n_o <= 1'b0;
		end else if (!loading) begin
			mp_phase_r <= 1'b0;
			addr_step_strobe <= 1'b0;
			memory_address_out <= mode_s == cpc_pkg::MODE_MPAR_HI ? cpc_pkg::ADDR_HI_START
				: cpc_pkg::ADDR_LO_START;
			peripheral_write_strobe_o <= mode_s == cpc_pkg::MODE_MPAR_HI;
			peripheral_select_c_n_o <= mode_s == cpc_pkg::MODE_MPAR_HI;
		end else if (mpar && more && step_en && out_cnt_r == 4'h0) begin
			if (!mp_phase_r) begin
				addr_step_strobe <= 1'b1;
				mp_phase_r <= 1'b1;
			end else begin
				// strobe has been high a full step before the address moves
				addr_step_strobe <= 1'b0;
				mp_phase_r <= 1'b0;
				memory_address_out <= addr_nxt;
				peripheral_write_strobe_o <= addr_nxt[0];
				peripheral_select_c_n_o <= addr_nxt[1];
			end
		end
	end

	// ----------------------------------------------------------------
	// pin drivers and enables
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			init_n_o <= 1'b0;
			init_n_oe <= 1'b1;
			config_busy_high_flag <= 1'b1;
			config_busy_high_flag_oe <= 1'b1;
			config_busy_low_flag <= 1'b0;
			config_busy_low_flag_oe <= 1'b1;
			memory_address_oe <= 1'b0;
			peripheral_write_strobe_oe <= 1'b0;
			peripheral_select_c_n_oe <= 1'b0;
			addr_step_strobe_oe <= 1'b0;
			byte_ready <= 1'b0;
			byte_ready_oe <= 1'b0;
			serial_data_out_oe <= 1'b0;
			weak_pullup_en <= 1'b1;
			config_done <= 1'b0;
		end else begin
			init_n_o <= 1'b0; // open drain, only ever pulls low
			init_n_oe <= st_r == cpc_pkg::ST_POWER || st_r == cpc_pkg::ST_CLEAR;
			// status pins: fixed while configuring, software-owned afterwards
			config_busy_high_flag <= cfg_active || ctrl_r[cpc_pkg::CTRL_HIGH_VAL];
			config_busy_high_flag_oe <= cfg_active || ctrl_r[cpc_pkg::CTRL_HIGH_OE];
			config_busy_low_flag <= !cfg_active && ctrl_r[cpc_pkg::CTRL_LOW_VAL];
			config_busy_low_flag_oe <= cfg_active || ctrl_r[cpc_pkg::CTRL_LOW_OE];
			// mode outputs only in their own mode, strobes released after load
			memory_address_oe <= loading && mpar;
			peripheral_write_strobe_oe <= loading && mpar;
			peripheral_select_c_n_oe <= loading && mpar;
			addr_step_strobe_oe <= loading && mpar;
			byte_ready <= loading && more && out_cnt_r == 4'h0 && !cap_evt;
			byte_ready_oe <= loading && mode_r == cpc_pkg::MD_PERIPH;
			serial_data_out_oe <= loading;
			weak_pullup_en <= cfg_active;
			config_done <= !cfg_active;
		end
	end

	// ----------------------------------------------------------------
	// ahb-lite slave, zero wait states, always okay
	// ----------------------------------------------------------------
	logic wr_pend_r; // write data phase pending
	logic [7:0] wr_addr_r; // its address
	logic addr_ph; // valid address phase
	logic [31:0] rd_mux; // read value at the address phase
	assign addr_ph = hsel && hready && htrans[1];
	always_comb begin
		unique case (haddr[7:0])
			cpc_pkg::ADDR_CTRL: rd_mux = {27'h0, ctrl_r};
			cpc_pkg::ADDR_LEN: rd_mux = {16'h0, len_r};
			cpc_pkg::ADDR_STAT: rd_mux = {21'h0, byte_ready, por_long_r, config_done, 1'b0,
				mode_raw_r, 1'b0, st_r};
			cpc_pkg::ADDR_DATA: rd_mux = {byte_cnt_r, 8'h00, cfg_byte};
			default: rd_mux = 32'h0000_0000; // unmapped reads zero
		endcase
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			hreadyout <= 1'b0;
			hresp <= 1'b0;
			hrdata <= 32'h0000_0000;
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			ctrl_r <= cpc_pkg::CTRL_RST;
			len_r <= cpc_pkg::LEN_RST;
			restart_r <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend_r <= addr_ph && hwrite;
			wr_addr_r <= haddr[7:0];
			restart_r <= 1'b0;
			if (addr_ph && !hwrite) begin
				hrdata <= rd_mux;
			end
			if (wr_pend_r && wr_addr_r == cpc_pkg::ADDR_CTRL) begin
				ctrl_r <= {hwdata[4:1], 1'b0};
				restart_r <= hwdata[cpc_pkg::CTRL_RESTART];
			end
			if (wr_pend_r && wr_addr_r == cpc_pkg::ADDR_LEN) begin
				len_r <= hwdata[15:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_BUSY_HIGH: assert property (@(posedge sys_clk) disable iff (!resetn)
		cfg_active |=> config_busy_high_flag && config_busy_high_flag_oe)
		else $error("busy-high pin not high during configuration");
	AST_BUSY_LOW: assert property (@(posedge sys_clk) disable iff (!resetn)
		cfg_active |=> !config_busy_low_flag && config_busy_low_flag_oe)
		else $error("busy-low pin not low during configuration");
	AST_INIT_LOW: assert property (@(posedge sys_clk) disable iff (!resetn)
		(st_r == cpc_pkg::ST_CLEAR) |=> init_n_oe && !init_n_o)
		else $error("init pin released while clearing");
	AST_HOLDOFF: assert property (@(posedge sys_clk) disable iff (!resetn)
		(st_r == cpc_pkg::ST_HOLD && !init_s && !restart_r) |=> st_r == cpc_pkg::ST_HOLD)
		else $error("left hold-off while init line low");
	AST_CAPTURE: assert property (@(posedge sys_clk) disable iff (!resetn)
		cap_evt |=> cfg_byte_valid && cfg_byte == $past(byte_s) && !byte_ready)
		else $error("peripheral byte not captured at strobe release");
	AST_ADDR_BITS: assert property (@(posedge sys_clk) disable iff (!resetn)
		memory_address_oe |-> peripheral_write_strobe_o == memory_address_out[0]
		&& peripheral_select_c_n_o == memory_address_out[1] && peripheral_write_strobe_oe)
		else $error("low address bits not on strobe pins");
	AST_STEP_FIRST: assert property (@(posedge sys_clk) disable iff (!resetn)
		(memory_address_oe && $past(memory_address_oe) && $changed(memory_address_out))
		|-> $past(addr_step_strobe) && !$past(addr_step_strobe, 5))
		else $error("address changed without a step strobe rise");
	AST_PULLUP: assert property (@(posedge sys_clk) disable iff (!resetn)
		(st_r == cpc_pkg::ST_DONE) |=> !weak_pullup_en && config_done)
		else $error("pull-ups still on after load");
	AST_MODE_PER: assert property (@(posedge sys_clk) disable iff (!resetn)
		(st_r == cpc_pkg::ST_HOLD && init_s && mode_s == cpc_pkg::MODE_PERIPH && !restart_r)
		|=> mode_r == cpc_pkg::MD_PERIPH && mode_raw_r == cpc_pkg::MODE_PERIPH)
		else $error("peripheral code not decoded");
	AST_AFTER_LOW: assert property (@(posedge sys_clk) disable iff (!resetn)
		(!cfg_active && ctrl_r[2:1] == 2'b11) |=> config_busy_low_flag && config_busy_low_flag_oe)
		else $error("busy-low pin not driven high after load");
endmodule

//--- verification/cpc_far_side.sv
// Purpose: far side model, configuration memory plus serial source
// Assumes: memory byte is a fixed function of the address
// Notes: link clock is parked high between frames
`timescale 1ns/100ps
module cpc_far_side (
	input wire logic go,
	input wire logic [15:0] memory_address_out,
	input wire logic memory_address_oe,
	output logic cclk_in,
	output logic [7:0] config_byte_bus
);
	// ----------------------------------------------------------------
	// memory and serial source
	// ----------------------------------------------------------------
	localparam logic [7:0] SER_BYTE = 8'ha5; // byte sent in one serial frame
	logic din = 1'b1; // serial data line
	initial cclk_in = 1'b1;
	// undriven bits track the inverse address so a stale value cannot match
	assign config_byte_bus = memory_address_oe ? (memory_address_out[7:0] ^ 8'h5a) :
		{~memory_address_out[7:1], din};
	// one frame, msb first, data set while the clock is low
	always @(posedge go) begin
		#20000;
		for (int i = 7; i >= 0; i--) begin
			cclk_in = 1'b0;
			din = SER_BYTE[i];
			#400;
			cclk_in = 1'b1;
			#400;
		end
		din = ~SER_BYTE[0]; // line no longer holds the last bit
	end
endmodule

//--- verification/config_port_pin_control_tb.sv
// Purpose: self-checking bench for the configuration port pin control
// Assumes: shortened power-on delays of 64 and 128 cycles
// Notes: master parallel low, high, then slave serial runs
`timescale 1ns/100ps
module config_port_pin_control_tb;
	`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin bad_count++; \
		$display("wrong value %s exp %h got %h", nm, e, s); end end
	logic sys_clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0] htrans = 2'h0;
	logic [2:0] mode = 3'h4; // mode pins, bit 2 first
	logic hreadyout, init_n_oe, bh, bh_oe, bl, bl_oe, ws_o, ws_oe, csc_o, addr_oe, done, cbv, cclk;
	logic pu_en;
	// peripheral strobes held idle: selects high, write strobe low
	logic psa_n = 1'b1, psb_n = 1'b1, psc_n = 1'b1, pws = 1'b0;
	logic [15:0] addr;
	logic [7:0] cb, bus;
	int bad_count = 0, num_checks = 0;
	always #50 sys_clk = ~sys_clk;
	// ----------------------------------------------------------------
	// design and far side
	// ----------------------------------------------------------------
	cpc_top #(.POR_SHORT_P(64), .POR_LONG_P(128)) DUT (.sys_clk(sys_clk), .resetn(resetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(),
		.mode_select_bit0(mode[0]), .mode_select_bit1(mode[1]), .mode_select_bit2(mode[2]),
		.cclk_in(cclk), .init_n_i(~init_n_oe), .init_n_o(), .init_n_oe(init_n_oe),
		.config_busy_high_flag(bh), .config_busy_high_flag_oe(bh_oe),
		.config_busy_low_flag(bl), .config_busy_low_flag_oe(bl_oe),
		.peripheral_select_a_n(psa_n), .peripheral_select_b_n(psb_n),
		.peripheral_select_c_n_i(psc_n), .peripheral_select_c_n_o(csc_o),
		.peripheral_select_c_n_oe(), .peripheral_write_strobe_i(pws),
		.peripheral_write_strobe_o(ws_o), .peripheral_write_strobe_oe(ws_oe),
		.config_byte_bus(bus), .memory_address_out(addr), .memory_address_oe(addr_oe),
		.addr_step_strobe(), .addr_step_strobe_oe(), .byte_ready(), .byte_ready_oe(),
		.serial_data_out(), .serial_data_out_oe(), .weak_pullup_en(pu_en),
		.config_done(done), .cfg_byte(cb), .cfg_byte_valid(cbv));
	cpc_far_side far (.go(go), .memory_address_out(addr), .memory_address_oe(addr_oe),
		.cclk_in(cclk), .config_byte_bus(bus));
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task give_verdict;
		if (bad_count == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// one ahb single transfer; entered just after a rising edge
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h000000, a};
		@(posedge sys_clk);
		while (hreadyout !== 1'b1) @(posedge sys_clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge sys_clk);
		while (hreadyout !== 1'b1) @(posedge sys_clk);
		rd = hrdata;
	endtask
	// one load: n bytes from a0 counting up or down, then after-load pin state
	task run(input logic [2:0] m, input logic [31:0] c, input logic [7:0] n,
		input logic [15:0] a0, input logic dn);
		mode <= m;
		ahb(1'b1, 8'h04, {24'h000000, n});
		ahb(1'b1, 8'h00, c);
		go <= (m == 3'h7);
		for (int k = 0; k < n; k++) begin
			while (cbv !== 1'b1) @(posedge sys_clk);
			`CHK("byte", 8'((dn ? a0 - k[15:0] : a0 + k[15:0]) ^ 16'h005a), cb)
			`CHK("busy low", 1'b0, bl)
			`CHK("busy high", 1'b1, bh)
			if (addr_oe === 1'b1)
				`CHK("addr pins", addr[1:0], {csc_o, ws_o})
			@(posedge sys_clk);
		end
		while (done !== 1'b1) @(posedge sys_clk);
		repeat (2) @(posedge sys_clk);
		`CHK("after load", 6'h30, {bl, bl_oe, bh_oe, pu_en, ws_oe, addr_oe})
		go <= 1'b0;
	endtask
	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(posedge sys_clk);
		`CHK("reset pins", 5'h1b, {bh, bh_oe, bl, init_n_oe, pu_en})
		resetn <= 1'b1;
		repeat (2) @(posedge sys_clk);
		ahb(1'b0, 8'h00, 32'h0);
		`CHK("ctrl reset", 32'h00000006, rd)
		ahb(1'b0, 8'h04, 32'h0);
		`CHK("len reset", 32'h00000010, rd)
		ahb(1'b0, 8'h10, 32'h0);
		`CHK("unmapped", 32'h00000000, rd)
		run(3'h4, 32'h00000006, 8'h02, 16'h0000, 1'b0);
		ahb(1'b0, 8'h08, 32'h0);
		`CHK("status", 10'h344, rd[9:0])
		run(3'h6, 32'h00000007, 8'h02, 16'hffff, 1'b1);
		run(3'h7, 32'h00000007, 8'h01, 16'h00ff, 1'b0);
		give_verdict();
	end
	initial begin
		#1000000;
		bad_count++;
		give_verdict();
	end
endmodule
